// ### shared/dccfg_pkg.sv
// What this block does
// - Divide field picks sysclk divided by 1/2/4/8
// - Divide field ignored with local oscillator
// - Source bit: 0 local oscillator, 1 sysclk
// - Invert bit flips divided sysclk after divider
// - ADC invert flips SAR clock during sync
// - ADC invert ignored when sync off
// - Current limit bit: 0 low, 1 high
// - Sleep bit: 0 tie to battery, 1 float
// - Top bit reads zero, software writes zero
// - Register sits at SFR 0x96, page 0x0
// - Core regulator off in sleep, on in suspend
// - Sync aligns ADC tracking to converter cycle
package dccfg_pkg;

    // ------------------------------------------------------------
    // Register location and layout
    // ------------------------------------------------------------
    localparam logic [7:0] DCCFG_SFR_ADDR = 8'h96;
    localparam logic [3:0] DCCFG_SFR_PAGE = 4'h0;
    localparam logic [7:0] DCCFG_RESET = 8'h00;
    localparam logic [7:0] DCCFG_WRITE_MASK = 8'h7F;
    localparam int DCCFG_SRC_BIT = 0;
    localparam int DCCFG_SLP_BIT = 1;
    localparam int DCCFG_ILIM_BIT = 2;
    localparam int DCCFG_CINV_BIT = 3;
    localparam int DCCFG_AINV_BIT = 4;
    localparam int DCCFG_DIV_LSB = 5;
    localparam logic [2:0] DCCFG_CNT_RESET = 3'h0;

    // ------------------------------------------------------------
    // Decoded configuration fields
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] divide;
        logic adc_inv;
        logic clk_inv;
        logic peak_current_limit_select;
        logic sleep_float;
        logic src_sys;
    } dccfg_fields_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] page;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dccfg_sfr_t;

endpackage

// ### hdl/dccfg_divider.sv
`timescale 1ns/10ps
module dccfg_divider (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_divide,
    output logic o_tick,
    output logic o_level
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] half_mask;
    logic wrap;

    // ------------------------------------------------------------
    // Divider count
    // ------------------------------------------------------------
    // Terminal count chosen from the divide field; a change takes effect at once, not at wrap
    assign half_mask = (i_divide == 2'h0) ? 3'h0 :
                       (i_divide == 2'h1) ? 3'h1 :
                       (i_divide == 2'h2) ? 3'h3 : 3'h7;
    assign wrap = ((cnt_q & half_mask) == half_mask);
    assign cnt_d = wrap ? dccfg_pkg::DCCFG_CNT_RESET : cnt_q + 3'h1;
    assign o_tick = wrap;

    // Level is high for the first half of a period; held high throughout at divide by 1
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= dccfg_pkg::DCCFG_CNT_RESET;
            o_level <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_level <= (i_divide == 2'h0) ? 1'b1 :
                       ((cnt_d & half_mask) <= (half_mask >> 1));
        end
    end
endmodule

// ### hdl/dccfg_top.sv
`timescale 1ns/10ps
module dccfg_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [3:0] i_sfr_page,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic i_sync_enable,
    input wire logic i_sleep,
    input wire logic i_suspend,
    input wire logic i_conv_enable,
    input wire logic i_local_osc_clk,
    input wire logic i_adc_sar_clk,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    output logic o_conv_clk,
    output logic o_conv_clk_sys,
    output logic o_adc_sar_clk,
    output logic o_adc_sync_align,
    output logic o_peak_current_limit_select_high,
    output logic o_sleep_float,
    output logic o_sleep_tie_vbat,
    output logic o_core_reg_on
);
    logic [7:0] cfg_q;
    logic [7:0] rdata_q;
    logic sel;
    logic wr_hit;
    dccfg_pkg::dccfg_fields_t f;
    logic [1:0] div_eff;
    logic div_tick;
    logic div_level;
    logic src_q;
    logic inv_q;
    logic sys_clk_q;
    logic sleep_q;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    // Address and page decode
    assign sel = (i_sfr_addr == dccfg_pkg::DCCFG_SFR_ADDR) &&
                 (i_sfr_page == dccfg_pkg::DCCFG_SFR_PAGE);
    assign wr_hit = sel && i_sfr_wr;
    assign o_sfr_hit = sel && (i_sfr_wr || i_sfr_rd);

    // Top bit never stored, so it always reads zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= dccfg_pkg::DCCFG_RESET;
        end else if (wr_hit) begin
            cfg_q <= i_sfr_wdata & dccfg_pkg::DCCFG_WRITE_MASK;
        end
    end

    // Registered read data, zero when not selected
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= (sel && i_sfr_rd) ? cfg_q : 8'h00;
        end
    end
    assign o_sfr_rdata = rdata_q;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    assign f.divide = cfg_q[dccfg_pkg::DCCFG_DIV_LSB +: 2];
    assign f.adc_inv = cfg_q[dccfg_pkg::DCCFG_AINV_BIT];
    assign f.clk_inv = cfg_q[dccfg_pkg::DCCFG_CINV_BIT];
    assign f.peak_current_limit_select = cfg_q[dccfg_pkg::DCCFG_ILIM_BIT];
    assign f.sleep_float = cfg_q[dccfg_pkg::DCCFG_SLP_BIT];
    assign f.src_sys = cfg_q[dccfg_pkg::DCCFG_SRC_BIT];

    // ------------------------------------------------------------
    // Converter clock path
    // ------------------------------------------------------------
    // Divider held at pass-through while the local oscillator runs
    assign div_eff = src_q ? f.divide : 2'h0;

    dccfg_divider u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_divide(div_eff),
        .o_tick(div_tick),
        .o_level(div_level)
    );

    // Source and invert only change at a period boundary, avoiding runts
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            src_q <= 1'b0;
            inv_q <= 1'b0;
        end else if (div_tick) begin
            src_q <= f.src_sys;
            inv_q <= f.clk_inv;
        end
    end

    // Divided system clock as an enable-rate level; inversion swaps phase
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sys_clk_q <= 1'b0;
        end else begin
            sys_clk_q <= div_level ^ inv_q;
        end
    end
    assign o_conv_clk_sys = sys_clk_q;

    // Clock mux: local oscillator or divided system clock
    assign o_conv_clk = src_q ? sys_clk_q : i_local_osc_clk;

    // ------------------------------------------------------------
    // ADC synchronisation
    // ------------------------------------------------------------
    // Invert only while sync is on; 1 inverts, 0 passes
    assign o_adc_sar_clk = i_adc_sar_clk ^
                           (i_sync_enable & f.adc_inv);
    assign o_adc_sync_align = i_sync_enable;

    // ------------------------------------------------------------
    // Analog settings and power modes
    // ------------------------------------------------------------
    assign o_peak_current_limit_select_high = f.peak_current_limit_select;

    // Sleep connection only applies with converter on and device asleep
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= i_sleep;
        end
    end
    assign o_sleep_float = sleep_q & i_conv_enable & f.sleep_float;
    assign o_sleep_tie_vbat = sleep_q & i_conv_enable &
                              ~f.sleep_float;

    // Regulator off only in sleep; suspend keeps it on
    assign o_core_reg_on = ~sleep_q | i_suspend;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // One clock domain, so clock and reset are given once
    default clocking assert_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Cycles since the last wrap; a write makes the period unclean
    logic [2:0] gap_q;
    logic clean_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_q <= 3'h0;
            clean_q <= 1'b0;
        end else if (div_tick) begin
            gap_q <= 3'h0;
            clean_q <= !wr_hit;
        end else begin
            gap_q <= gap_q + 3'h1;
            clean_q <= clean_q && !wr_hit;
        end
    end

    // Register, clock path and power mode checks
    top_bit_zero_a: assert property (cfg_q[7] == 1'b0)
        else $error("top bit stored");
    write_lands_a: assert property (
        wr_hit |=> cfg_q ==
        ($past(i_sfr_wdata) & dccfg_pkg::DCCFG_WRITE_MASK))
        else $error("write lost");
    no_foreign_wr_a: assert property (
        (i_sfr_wr && !sel) |=> $stable(cfg_q))
        else $error("foreign write stored");
    local_src_a: assert property (
        !src_q |-> o_conv_clk == i_local_osc_clk)
        else $error("local osc not passed");
    local_nodiv_a: assert property (!src_q |-> div_eff == 2'h0)
        else $error("div active");
    div8_period_a: assert property (
        (div_tick && div_eff == 2'h3 && clean_q) |-> gap_q == 3'h7)
        else $error("div8 period");
    div2_period_a: assert property (
        (div_tick && div_eff == 2'h1 && clean_q) |-> gap_q == 3'h1)
        else $error("div2 period");
    src_at_tick_a: assert property (
        $changed(src_q) |-> $past(div_tick))
        else $error("source switched mid period");
    inv_follow_a: assert property (
        ##1 sys_clk_q == ($past(div_level) ^ $past(inv_q)))
        else $error("invert wrong");
    adc_inv_a: assert property (
        o_adc_sar_clk == (i_adc_sar_clk ^ (i_sync_enable & f.adc_inv)))
        else $error("sar invert wrong");
    adc_nosync_a: assert property (
        !i_sync_enable |-> o_adc_sar_clk == i_adc_sar_clk)
        else $error("sar inverted without sync");
    ilim_follow_a: assert property (
        wr_hit |=> o_peak_current_limit_select_high ==
        $past(i_sfr_wdata[dccfg_pkg::DCCFG_ILIM_BIT]))
        else $error("peak_current_limit_select wrong");
    sleep_conn_a: assert property (
        !(o_sleep_float && o_sleep_tie_vbat))
        else $error("sleep both");
    reg_sleep_a: assert property (
        (i_sleep && !i_suspend) |=> !o_core_reg_on || i_suspend)
        else $error("regulator on in sleep");

    // Main scenarios
    cov_div8_c: cover property (src_q && div_eff == 2'h3);
    cov_inv_c: cover property (src_q && inv_q);
    cov_sync_c: cover property (i_sync_enable && f.adc_inv);
    cov_sleep_c: cover property (o_sleep_float);
endmodule

// ### verification/dccfg_top_tb.sv
`timescale 1ns/10ps
module dccfg_top_tb;
    // ------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_sfr_addr = 8'h00;
    logic [3:0] i_sfr_page = 4'h0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic i_sfr_rd = 1'b0;
    logic i_sync_enable = 1'b0;
    logic i_sleep = 1'b0;
    logic i_suspend = 1'b0;
    logic i_conv_enable = 1'b0;
    logic i_local_osc_clk = 1'b0;
    logic i_adc_sar_clk = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_sfr_hit, o_conv_clk, o_conv_clk_sys, o_adc_sar_clk;
    logic o_adc_sync_align, o_peak_current_limit_select_high, o_sleep_float;
    logic o_sleep_tie_vbat, o_core_reg_on;
    int n_errors = 0;
    int n_tests = 0;

    dccfg_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
        .i_sfr_page(i_sfr_page), .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
        .i_sync_enable(i_sync_enable), .i_sleep(i_sleep),
        .i_suspend(i_suspend), .i_conv_enable(i_conv_enable),
        .i_local_osc_clk(i_local_osc_clk), .i_adc_sar_clk(i_adc_sar_clk),
        .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
        .o_conv_clk(o_conv_clk), .o_conv_clk_sys(o_conv_clk_sys),
        .o_adc_sar_clk(o_adc_sar_clk), .o_adc_sync_align(o_adc_sync_align),
        .o_peak_current_limit_select_high(o_peak_current_limit_select_high), .o_sleep_float(o_sleep_float),
        .o_sleep_tie_vbat(o_sleep_tie_vbat), .o_core_reg_on(o_core_reg_on));

    // 40 MHz system clock; local oscillator runs unrelated to the divider
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) i_local_osc_clk <= ~i_local_osc_clk;

    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic stop_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Strobe is held one full cycle so the edge sampling it is unambiguous
    task automatic sfr_write(input logic [7:0] a, input logic [3:0] p,
                             input logic [7:0] d, input logic hit);
        @(posedge i_clk);
        i_sfr_addr <= a;
        i_sfr_page <= p;
        i_sfr_wdata <= d;
        i_sfr_wr <= 1'b1;
        @(negedge i_clk);
        chk_bit(o_sfr_hit, hit);
        @(posedge i_clk);
        i_sfr_wr <= 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] a, input logic [3:0] p,
                            input logic [7:0] exp);
        @(posedge i_clk);
        i_sfr_addr <= a;
        i_sfr_page <= p;
        i_sfr_rd <= 1'b1;
        @(negedge i_clk);
        @(posedge i_clk);
        i_sfr_rd <= 1'b0;
        @(negedge i_clk);
        chk_byte(o_sfr_rdata, exp);
    endtask

    // Period and high time of the converter clock, sampled mid-cycle
    task automatic measure(input logic [7:0] cfg, input int per);
        logic prev;
        logic rise;
        int n;
        int h;
        sfr_write(8'h96, 4'h0, cfg, 1'b1);
        sfr_read(8'h96, 4'h0, cfg);
        repeat (24) @(negedge i_clk);
        n = 0;
        rise = 1'b0;
        prev = o_conv_clk;
        while (!rise && n < 40) begin
            @(negedge i_clk);
            rise = (prev === 1'b0) && (o_conv_clk === 1'b1);
            prev = o_conv_clk;
            n++;
        end
        n = 0;
        h = 0;
        rise = 1'b0;
        while (!rise && n < 40) begin
            if (o_conv_clk === 1'b1) h++;
            @(negedge i_clk);
            rise = (prev === 1'b0) && (o_conv_clk === 1'b1);
            prev = o_conv_clk;
            n++;
        end
        chk_byte(8'(n), 8'(per));
        chk_byte(8'(h), 8'(per / 2));
        chk_bit(o_conv_clk_sys, o_conv_clk);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk_bit(o_core_reg_on, 1'b1);
        sfr_read(8'h96, 4'h0, 8'h00);
        sfr_write(8'h96, 4'h0, 8'h7F, 1'b1);
        sfr_read(8'h96, 4'h0, 8'h7F);
        sfr_write(8'h97, 4'h0, 8'h00, 1'b0);
        sfr_write(8'h96, 4'h1, 8'h00, 1'b0);
        sfr_read(8'h96, 4'h1, 8'h00);
        sfr_read(8'h96, 4'h0, 8'h7F);
        // Local oscillator wins whatever the divide field holds
        sfr_write(8'h96, 4'h0, 8'h60, 1'b1);
        // Source switches only at the next wrap, up to eight cycles away
        repeat (10) @(negedge i_clk);
        repeat (4) begin
            @(negedge i_clk);
            chk_bit(o_conv_clk, i_local_osc_clk);
        end
        sfr_write(8'h96, 4'h0, 8'h01, 1'b1);
        measure(8'h21, 2);
        measure(8'h41, 4);
        measure(8'h61, 8);
        measure(8'h69, 8);
        measure(8'h29, 2);
        // ADC clock invert only while sync is on, level 1 inverts
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            i_sync_enable <= k[0];
            i_adc_sar_clk <= k[1];
            sfr_write(8'h96, 4'h0, {3'h0, k[2], 4'h0}, 1'b1);
            @(negedge i_clk);
            chk_bit(o_adc_sar_clk, k[1] ^ (k[0] & k[2]));
            chk_bit(o_adc_sync_align, k[0]);
        end
        // Current limit and sleep connection over all input levels
        for (int k = 0; k < 16; k++) begin
            sfr_write(8'h96, 4'h0, {5'h00, k[0], k[1], 1'b0}, 1'b1);
            @(posedge i_clk);
            i_sleep <= k[2];
            i_conv_enable <= k[3];
            repeat (3) @(negedge i_clk);
            chk_bit(o_peak_current_limit_select_high, k[0]);
            chk_bit(o_sleep_float, k[1] & k[2] & k[3]);
            chk_bit(o_sleep_tie_vbat, ~k[1] & k[2] & k[3]);
            chk_bit(o_core_reg_on, ~k[2]);
        end
        @(posedge i_clk);
        i_sleep <= 1'b1;
        i_suspend <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk_bit(o_core_reg_on, 1'b1);
        stop_test();
    end

    // Whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        stop_test();
    end
endmodule
